// ==== spi_frame_port.v ====
// spi slave frame shifter with pin synchronisers, lsb first
`timescale 1ns/1ns
`include "wdbus_defines.vh"
module spi_frame_port #(
    parameter FRAME_BITS = `FRAME_BITS
) (
    input wire clk,
    input wire sys_rst,
    input wire spi_cs_n,
    input wire spi_sck,
    input wire spi_mosi,
    input wire [7:0] rd_data,
    output wire spi_miso,
    output wire spi_miso_oe,
    output wire addr_valid,
    output wire frame_done,
    output wire frame_ok,
    output wire [15:0] frame
);
    localparam [2:0] PIN_IDLE = 3'h1;
    wire [2:0] pins;
    reg [2:0] s1_r, s2_r, s3_r, flt_r, flt_d_r;
    reg [4:0] cnt_r;
    reg [15:0] sh_r;
    reg [7:0] tx_r;
    reg miso_r, oe_r, addr_valid_r, done_r, ok_r;
    wire cs_n, sck, mosi, sck_rise, sck_fall, cs_fall, cs_rise;

    assign pins = {spi_mosi, spi_sck, spi_cs_n};
    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : sync
            // a level is taken only once stages two and three agree
            always @(posedge clk) begin
                if (sys_rst) begin
                    s1_r[i] <= PIN_IDLE[i];
                    s2_r[i] <= PIN_IDLE[i];
                    s3_r[i] <= PIN_IDLE[i];
                    flt_r[i] <= PIN_IDLE[i];
                    flt_d_r[i] <= PIN_IDLE[i];
                end else begin
                    s1_r[i] <= pins[i];
                    s2_r[i] <= s1_r[i];
                    s3_r[i] <= s2_r[i];
                    if (s2_r[i] == s3_r[i]) begin
                        flt_r[i] <= s3_r[i];
                    end
                    flt_d_r[i] <= flt_r[i];
                end
            end
        end
    endgenerate

    assign cs_n = flt_r[0];
    assign sck = flt_r[1];
    assign mosi = flt_r[2];
    assign sck_rise = sck & ~flt_d_r[1] & ~cs_n;
    assign sck_fall = ~sck & flt_d_r[1] & ~cs_n;
    assign cs_fall = ~cs_n & flt_d_r[0];
    assign cs_rise = cs_n & ~flt_d_r[0];

    always @(posedge clk) begin
        if (sys_rst) begin
            cnt_r <= 5'h00;
            sh_r <= 16'h0000;
            tx_r <= 8'h00;
            miso_r <= 1'b0;
            oe_r <= 1'b0;
            addr_valid_r <= 1'b0;
            done_r <= 1'b0;
            ok_r <= 1'b0;
        end else begin
            addr_valid_r <= sck_rise && (cnt_r == 5'h07);
            done_r <= cs_rise;
            ok_r <= cs_rise && (cnt_r == FRAME_BITS[4:0]);
            oe_r <= ~cs_n;
            if (cs_fall) begin
                cnt_r <= 5'h00;
                tx_r <= 8'h00;
                miso_r <= 1'b0;
            end else begin
                if (sck_rise) begin
                    sh_r <= {mosi, sh_r[15:1]};
                    if (cnt_r != 5'h1F) begin
                        cnt_r <= cnt_r + 5'h01;
                    end
                end
                if (addr_valid_r) begin
                    tx_r <= rd_data;
                end else if (sck_fall) begin
                    miso_r <= tx_r[0];
                    tx_r <= {1'b0, tx_r[7:1]};
                end
            end
        end
    end

    assign spi_miso = miso_r;
    assign spi_miso_oe = oe_r;
    assign addr_valid = addr_valid_r;
    assign frame_done = done_r;
    assign frame_ok = ok_r;
    assign frame = sh_r;
endmodule // spi_frame_port

// ==== spi_host_model.sv ====
// host model sending lsb-first 16-bit frames, sck idle low
`timescale 1ns/1ns
module spi_host_model (
    input wire clk,
    input wire spi_miso,
    output reg spi_cs_n,
    output reg spi_sck,
    output reg spi_mosi
);
    integer i;
    initial begin
        spi_cs_n = 1'b1;
        spi_sck = 1'b0;
        spi_mosi = 1'b0;
    end
    task hold(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    // sck levels of 8 clk leave margin over the pin filter
    task xfer(input [6:0] a, input w, input [7:0] d, output [7:0] q);
        reg [15:0] f;
        begin
            f = {d, w, a};
            q = 8'h00;
            hold(1);
            spi_cs_n = 1'b0;
            for (i = 0; i < 16; i = i + 1) begin
                spi_mosi = f[i];
                hold(8);
                if (i > 7) q[i - 8] = spi_miso;
                spi_sck = 1'b1;
                hold(8);
                spi_sck = 1'b0;
            end
            hold(8);
            spi_cs_n = 1'b1;
            // released line shows no stale bit
            spi_mosi = ~spi_mosi;
            hold(16);
        end
    endtask
endmodule // spi_host_model

// ==== watchdog_and_bus_mode_control_regs.v ====
// watchdog control and bus mode control registers behind the spi port
`timescale 1ns/1ns
`include "wdbus_defines.vh"
module watchdog_and_bus_mode_control_regs (
    input wire clk,
    input wire sys_rst,
    input wire spi_cs_n,
    input wire spi_sck,
    input wire spi_mosi,
    output wire spi_miso,
    output wire spi_miso_oe,
    input wire soft_reset,
    input wire restart,
    input wire [1:0] chip_mode,
    input wire bus_wake,
    input wire dog_fail,
    input wire dog_serviced,
    input wire hw_stop_dis_we,
    input wire hw_stop_dis_val,
    input wire hw_bus_wake_we,
    input wire hw_bus_wake_val,
    input wire hw_period_we,
    input wire [2:0] hw_period_val,
    input wire hw_can_we,
    input wire [1:0] hw_can_val,
    input wire hw_lin_first_we,
    input wire [1:0] hw_lin_first_val,
    input wire hw_lin_second_we,
    input wire [1:0] hw_lin_second_val,
    input wire hw_lin_third_we,
    input wire [1:0] hw_lin_third_val,
    output wire spi_fail,
    output wire dog_active,
    output wire dog_stop_disable,
    output wire dog_window_select,
    output wire dog_start_on_bus_wake,
    output wire dog_max_three,
    output wire [2:0] dog_period,
    output wire [15:0] dog_period_ms,
    output wire dog_period_valid,
    output wire dog_long_window_start,
    output wire dog_reset_req,
    output wire lin_flash,
    output wire lin_low_slope,
    output wire lin_tx_timeout_en,
    output wire [1:0] can_mode,
    output wire [1:0] lin_mode_first,
    output wire [1:0] lin_mode_second,
    output wire [1:0] lin_mode_third
);
    reg [7:0] dog_r, dog_nxt;
    reg [7:0] bus_one_r, bus_one_nxt;
    reg [7:0] bus_two_r, bus_two_nxt;
    reg [7:0] rd_data;
    reg fail_r, fail_nxt;
    reg [1:0] rst_cnt_r;
    reg dog_reset_r;
    reg dog_active_r;
    reg long_win_r;
    reg [15:0] ms_r;
    reg ms_valid_r;
    reg [1:0] can_eff_r;
    reg [1:0] lin_mode_first_eff_r;
    reg [1:0] lin_mode_second_eff_r;
    reg [1:0] lin_mode_third_eff_r;
    wire addr_valid;
    wire frame_done;
    wire frame_ok;
    wire [15:0] frame;
    wire [6:0] rd_addr;
    wire [6:0] wr_addr;
    wire wr_req;
    wire [7:0] wr_data;
    wire low_power;
    wire in_stop;

    spi_frame_port #(
        .FRAME_BITS(`FRAME_BITS)
    ) port_u (
        .clk(clk),
        .sys_rst(sys_rst),
        .spi_cs_n(spi_cs_n),
        .spi_sck(spi_sck),
        .spi_mosi(spi_mosi),
        .rd_data(rd_data),
        .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe),
        .addr_valid(addr_valid),
        .frame_done(frame_done),
        .frame_ok(frame_ok),
        .frame(frame)
    );

    // while only the first byte is in, it sits in the top half of the shifter
    assign rd_addr = frame[14:8];
    assign wr_addr = frame[6:0];
    // a write only counts for a complete frame of exactly sixteen bits
    assign wr_req = frame_done && frame_ok && frame[`WR_BIT];
    assign wr_data = frame[15:8];
    assign low_power = (chip_mode == `MODE_STOP) || (chip_mode == `MODE_SLEEP);
    assign in_stop = (chip_mode == `MODE_STOP);

    // read data use the next values so a same-cycle hardware update is seen
    always @* begin
        rd_data = 8'h00;
        if (rd_addr == `ADDR_DOG_CTRL) begin
            rd_data = dog_nxt & `DOG_RD_MASK;
        end else if (rd_addr == `ADDR_BUS_ONE) begin
            rd_data = bus_one_nxt & `BUS_ONE_WMASK;
        end else if (rd_addr == `ADDR_BUS_TWO) begin
            rd_data = bus_two_nxt & `BUS_TWO_WMASK;
        end
    end

    always @* begin
        dog_nxt = dog_r;
        bus_one_nxt = bus_one_r;
        bus_two_nxt = bus_two_r;
        fail_nxt = 1'b0;
        if (soft_reset) begin
            dog_nxt = `DOG_POR;
            bus_one_nxt = `BUS_ONE_POR;
            bus_two_nxt = `BUS_TWO_POR;
        end else if (restart) begin
            dog_nxt = (dog_r & `DOG_RESTART_KEEP) | `DOG_RESTART_SET;
            bus_one_nxt = bus_one_r & `BUS_ONE_WMASK;
            bus_two_nxt = bus_two_r & `BUS_TWO_WMASK;
        end else begin
            if (wr_req) begin
                if (wr_addr == `ADDR_DOG_CTRL) begin
                    // odd parity drops the whole byte, not just bad bits
                    if (^wr_data) begin
                        fail_nxt = 1'b1;
                    end else begin
                        dog_nxt = wr_data & `DOG_RD_MASK;
                    end
                end else if (wr_addr == `ADDR_BUS_ONE) begin
                    bus_one_nxt = wr_data & `BUS_ONE_WMASK;
                end else if (wr_addr == `ADDR_BUS_TWO) begin
                    bus_two_nxt = wr_data & `BUS_TWO_WMASK;
                end
            end
            // hardware updates win over a host write in the same cycle
            if (hw_stop_dis_we) begin
                dog_nxt[`DOG_STOP_DIS_BIT] = hw_stop_dis_val;
            end
            if (hw_bus_wake_we) begin
                dog_nxt[`DOG_BUS_WAKE_BIT] = hw_bus_wake_val;
            end
            if (hw_period_we) begin
                dog_nxt[2:0] = hw_period_val;
            end
            if (hw_can_we) begin
                bus_one_nxt[1:0] = hw_can_val;
            end
            if (hw_lin_first_we) begin
                bus_one_nxt[4:3] = hw_lin_first_val;
            end
            if (hw_lin_second_we) begin
                bus_two_nxt[1:0] = hw_lin_second_val;
            end
            if (hw_lin_third_we) begin
                bus_two_nxt[4:3] = hw_lin_third_val;
            end
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            dog_r <= `DOG_POR;
            bus_one_r <= `BUS_ONE_POR;
            bus_two_r <= `BUS_TWO_POR;
            fail_r <= 1'b0;
        end else begin
            dog_r <= dog_nxt;
            bus_one_r <= bus_one_nxt;
            bus_two_r <= bus_two_nxt;
            fail_r <= fail_nxt;
        end
    end

    // stored bits stay put in low power; only the driven mode is degraded
    function [1:0] trx_eff;
        input [1:0] code;
        input lp;
        begin
            if (lp && (code == `TRX_NORMAL)) begin
                trx_eff = `TRX_WAKE;
            end else begin
                trx_eff = code;
            end
        end
    endfunction

    always @(posedge clk) begin
        if (sys_rst) begin
            can_eff_r <= `TRX_OFF;
            lin_mode_first_eff_r <= `TRX_OFF;
            lin_mode_second_eff_r <= `TRX_OFF;
            lin_mode_third_eff_r <= `TRX_OFF;
        end else begin
            can_eff_r <= trx_eff(bus_one_r[1:0], low_power);
            lin_mode_first_eff_r <= trx_eff(bus_one_r[4:3], low_power);
            lin_mode_second_eff_r <= trx_eff(bus_two_r[1:0], low_power);
            lin_mode_third_eff_r <= trx_eff(bus_two_r[4:3], low_power);
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            ms_r <= `DOG_MS_0;
            ms_valid_r <= 1'b1;
        end else begin
            ms_valid_r <= 1'b1;
            case (dog_r[2:0])
                3'h0: ms_r <= `DOG_MS_0;
                3'h1: ms_r <= `DOG_MS_1;
                3'h2: ms_r <= `DOG_MS_2;
                3'h3: ms_r <= `DOG_MS_3;
                3'h4: ms_r <= `DOG_MS_4;
                3'h5: ms_r <= `DOG_MS_5;
                default: begin
                    // undefined and reserved codes fall back to the shortest period
                    ms_r <= `DOG_MS_0;
                    ms_valid_r <= 1'b0;
                end
            endcase
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            dog_active_r <= 1'b1;
            long_win_r <= 1'b0;
        end else begin
            dog_active_r <= ~(in_stop && dog_r[`DOG_STOP_DIS_BIT]);
            long_win_r <= bus_wake && in_stop && dog_r[`DOG_BUS_WAKE_BIT];
        end
    end

    // consecutive failure count survives a restart, cleared by service, soft reset or por
    always @(posedge clk) begin
        if (sys_rst || soft_reset) begin
            rst_cnt_r <= 2'h0;
            dog_reset_r <= 1'b0;
        end else begin
            dog_reset_r <= 1'b0;
            if (dog_fail) begin
                if (dog_r[`DOG_MAX3_BIT] && (rst_cnt_r == `DOG_MAX_RESETS)) begin
                    dog_reset_r <= 1'b0;
                end else begin
                    dog_reset_r <= 1'b1;
                    if (rst_cnt_r != `DOG_MAX_RESETS) begin
                        rst_cnt_r <= rst_cnt_r + 2'h1;
                    end
                end
            end else if (dog_serviced) begin
                rst_cnt_r <= 2'h0;
            end
        end
    end

    assign spi_fail = fail_r;
    assign dog_active = dog_active_r;
    assign dog_stop_disable = dog_r[`DOG_STOP_DIS_BIT];
    assign dog_window_select = dog_r[`DOG_WIN_BIT];
    assign dog_start_on_bus_wake = dog_r[`DOG_BUS_WAKE_BIT];
    assign dog_max_three = dog_r[`DOG_MAX3_BIT];
    assign dog_period = dog_r[2:0];
    assign dog_period_ms = ms_r;
    assign dog_period_valid = ms_valid_r;
    assign dog_long_window_start = long_win_r;
    assign dog_reset_req = dog_reset_r;
    assign lin_flash = bus_one_r[`LIN_FLASH_BIT];
    assign lin_low_slope = bus_one_r[`LIN_LOW_SLOPE_BIT];
    assign lin_tx_timeout_en = bus_one_r[`LIN_TX_TO_BIT];
    assign can_mode = can_eff_r;
    assign lin_mode_first = lin_mode_first_eff_r;
    assign lin_mode_second = lin_mode_second_eff_r;
    assign lin_mode_third = lin_mode_third_eff_r;
endmodule // watchdog_and_bus_mode_control_regs

// ==== watchdog_and_bus_mode_control_regs_bench.sv ====
// self-checking bench for the watchdog and bus mode register slice
`timescale 1ns/1ns
module watchdog_and_bus_mode_control_regs_bench;
    reg clk = 1'b0;
    reg sys_rst = 1'b1;
    reg soft_reset = 1'b0;
    reg restart = 1'b0;
    reg bus_wake = 1'b0;
    reg dog_fail = 1'b0;
    reg dog_serviced = 1'b0;
    reg [1:0] chip_mode = 2'h0;
    reg [6:0] hw_we = 7'h00;
    reg [2:0] hw_v = 3'h0;
    wire spi_cs_n, spi_sck, spi_mosi, spi_miso, spi_fail, dog_active, lin_flash, lin_low;
    wire stop_dis, win_sel, wake_st, max3, per_ok, long_win, rst_req, lin_to;
    wire [2:0] per;
    wire [15:0] per_ms;
    wire [1:0] can_m, lin_mode_first_m, lin_mode_second_m, lin_mode_third_m;
    wire miso_oe;
    reg [7:0] m [0:2];
    reg [7:0] q;
    reg [7:0] d;
    integer n_mismatch = 0;
    integer check_count = 0;
    integer cyc = 0, n_fail = 0, n_req = 0, n_win = 0, e = 0, i;
    integer n_oe = 0;
    always #5 clk = ~clk;
    spi_host_model i_host (.clk(clk), .spi_miso(spi_miso), .spi_cs_n(spi_cs_n),
        .spi_sck(spi_sck), .spi_mosi(spi_mosi));
    watchdog_and_bus_mode_control_regs i_dut (.clk(clk), .sys_rst(sys_rst),
        .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe(miso_oe), .soft_reset(soft_reset), .restart(restart),
        .chip_mode(chip_mode),
        .bus_wake(bus_wake), .dog_fail(dog_fail), .dog_serviced(dog_serviced),
        .hw_stop_dis_we(hw_we[0]), .hw_stop_dis_val(hw_v[0]), .hw_bus_wake_we(hw_we[1]),
        .hw_bus_wake_val(hw_v[0]), .hw_period_we(hw_we[2]), .hw_period_val(hw_v),
        .hw_can_we(hw_we[3]), .hw_can_val(hw_v[1:0]), .hw_lin_first_we(hw_we[4]),
        .hw_lin_first_val(hw_v[1:0]), .hw_lin_second_we(hw_we[5]),
        .hw_lin_second_val(hw_v[1:0]), .hw_lin_third_we(hw_we[6]),
        .hw_lin_third_val(hw_v[1:0]), .spi_fail(spi_fail), .dog_active(dog_active),
        .dog_stop_disable(stop_dis), .dog_window_select(win_sel),
        .dog_start_on_bus_wake(wake_st), .dog_max_three(max3), .dog_period(per),
        .dog_period_ms(per_ms), .dog_period_valid(per_ok), .dog_long_window_start(long_win),
        .dog_reset_req(rst_req), .lin_flash(lin_flash), .lin_low_slope(lin_low),
        .lin_tx_timeout_en(lin_to), .can_mode(can_m), .lin_mode_first(lin_mode_first_m),
        .lin_mode_second(lin_mode_second_m), .lin_mode_third(lin_mode_third_m));
    function [1:0] eff(input [1:0] c);
        eff = (chip_mode != 2'h0 && c == 2'h3) ? 2'h1 : c;
    endfunction
    // period in milliseconds for the defined codes only
    function [15:0] ms_of(input [2:0] c);
        begin
            case (c)
                3'h0: ms_of = 16'h000A;
                3'h1: ms_of = 16'h0014;
                3'h2: ms_of = 16'h0032;
                3'h3: ms_of = 16'h0064;
                3'h4: ms_of = 16'h00C8;
                3'h5: ms_of = 16'h01F4;
                default: ms_of = 16'h0000;
            endcase
        end
    endfunction
    task tick(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", check_count, n_mismatch);
            if (n_mismatch == 0 && check_count > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task check(input string nm, input [15:0] seen, input [15:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("unexpected %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task rd(input [6:0] ad, input [7:0] exp);
        begin
            i_host.xfer(ad, 1'b0, 8'h00, q);
            check("read data", q, exp);
        end
    endtask
    task wr(input [6:0] ad, input [7:0] dt);
        begin
            i_host.xfer(ad, 1'b1, dt, q);
            if (ad == 7'h03 && !(^dt)) m[0] = dt & 8'h7F;
            if (ad == 7'h04) m[1] = dt & 8'hFB;
            if (ad == 7'h05) m[2] = dt & 8'h1B;
        end
    endtask
    task vfy;
        reg [7:0] x;
        begin
            rd(7'h03, m[0]);
            rd(7'h04, m[1]);
            rd(7'h05, m[2]);
            check("dog bits", {stop_dis, win_sel, wake_st, max3, per}, m[0][6:0]);
            if (m[0][2:0] < 3'h6) check("period ms", per_ms, ms_of(m[0][2:0]));
            check("lin options", {lin_flash, lin_low, lin_to}, m[1][7:5]);
            x = {eff(m[1][1:0]), eff(m[1][4:3]), eff(m[2][1:0]), eff(m[2][4:3])};
            check("modes", {can_m, lin_mode_first_m, lin_mode_second_m, lin_mode_third_m}, x);
        end
    endtask
    task pulse(input integer s);
        begin
            case (s)
                0: bus_wake = 1'b1;
                1: dog_fail = 1'b1;
                2: dog_serviced = 1'b1;
                3: restart = 1'b1;
                default: soft_reset = 1'b1;
            endcase
            tick(1);
            {bus_wake, dog_fail, dog_serviced, restart, soft_reset} = 5'h00;
            tick(3);
        end
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        n_fail = n_fail + (spi_fail === 1'b1);
        n_req = n_req + (rst_req === 1'b1);
        n_win = n_win + (long_win === 1'b1);
        n_oe = n_oe + (miso_oe === 1'b1);
        if (cyc == 40000) begin
            n_mismatch = n_mismatch + 1;
            close_out;
        end
    end
    initial begin
        m[0] = 8'h14;
        m[1] = 8'h20;
        m[2] = 8'h00;
        void'($urandom(32'hE68D51D4));
        repeat (4) @(posedge clk);
        #1 sys_rst = 1'b0;
        tick(8);
        vfy;
        for (i = 0; i < 18; i = i + 1) begin
            d = $urandom;
            if (i % 2) d[7] = ^d[6:0];
            e = e + (i % 3 == 0 && ^d);
            wr(7'(3 + i % 3), d);
            rd(7'(3 + i % 3), m[i % 3]);
        end
        wr(7'h03, 8'h80);
        wr(7'h03, 8'hFF);
        wr(7'h04, 8'hFF);
        wr(7'h05, 8'hFF);
        rd(7'h7F, 8'h00);
        check("parity fails", n_fail, e + 1);
        check("miso enable", {n_oe > 0, miso_oe}, 2'h2);
        $display("done: register access");
        pulse(3);
        m[0] = (m[0] & 8'h18) | 8'h04;
        vfy;
        for (i = 0; i < 9; i = i + 1) begin
            hw_v = (i > 6) ? 3'(i - 2) : $urandom;
            hw_we[(i > 6) ? 2 : i] = 1'b1;
            tick(1);
            hw_we = 7'h00;
            case ((i > 6) ? 2 : i)
                0: m[0][6] = hw_v[0];
                1: m[0][4] = hw_v[0];
                2: m[0][2:0] = hw_v;
                3: m[1][1:0] = hw_v[1:0];
                4: m[1][4:3] = hw_v[1:0];
                5: m[2][1:0] = hw_v[1:0];
                default: m[2][4:3] = hw_v[1:0];
            endcase
            tick(3);
        end
        check("period valid", per_ok, m[0][2:0] < 3'h6);
        vfy;
        $display("done: restart and hardware update");
        wr(7'h04, 8'h1B);
        wr(7'h05, 8'h1A);
        chip_mode = 2'h2;
        tick(3);
        vfy;
        chip_mode = 2'h0;
        tick(3);
        vfy;
        wr(7'h04, 8'h19);
        chip_mode = 2'h1;
        tick(3);
        vfy;
        $display("done: low power modes");
        wr(7'h03, 8'h5C);
        chip_mode = 2'h2;
        tick(3);
        check("dog active", dog_active, 1'b0);
        e = n_win;
        pulse(0);
        check("long window", n_win, e + 1);
        e = n_req;
        for (i = 0; i < 4; i = i + 1) pulse(1);
        pulse(2);
        pulse(1);
        check("reset limit", n_req, e + 4);
        wr(7'h03, 8'h44);
        e = n_req + 3;
        for (i = 0; i < 3; i = i + 1) pulse(1);
        e = e - n_win;
        pulse(0);
        check("failure resets", n_req - n_win, e);
        chip_mode = 2'h0;
        tick(3);
        check("dog active", dog_active, 1'b1);
        pulse(4);
        m[0] = 8'h14;
        m[1] = 8'h20;
        m[2] = 8'h00;
        vfy;
        $display("done: watchdog events and soft reset");
        close_out;
    end
endmodule // watchdog_and_bus_mode_control_regs_bench

// ==== wdbus_chk.sv ====
// port assertions for the watchdog and bus mode register slice
`timescale 1ns/1ns
module wdbus_chk (
    input wire clk,
    input wire sys_rst,
    input wire [1:0] chip_mode,
    input wire bus_wake,
    input wire dog_fail,
    input wire spi_fail,
    input wire dog_active,
    input wire dog_stop_disable,
    input wire dog_start_on_bus_wake,
    input wire dog_max_three,
    input wire [2:0] dog_period,
    input wire [15:0] dog_period_ms,
    input wire dog_long_window_start,
    input wire dog_reset_req,
    input wire [1:0] can_mode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    chk_wake_start: assert property (
        bus_wake && chip_mode == 2'h2 && dog_start_on_bus_wake |=> dog_long_window_start)
        else $error("long window start missing");
    chk_wake_cause: assert property (
        dog_long_window_start |-> $past(bus_wake) && $past(dog_start_on_bus_wake))
        else $error("long window start without wake");
    chk_fail_reset: assert property (
        dog_fail && !dog_max_three |=> dog_reset_req)
        else $error("reset request missing");
    chk_reset_cause: assert property (
        dog_reset_req |-> $past(dog_fail))
        else $error("reset request without failure");
    chk_fail_pulse: assert property (
        spi_fail |=> !spi_fail)
        else $error("spi failure flag too long");
    chk_period_ms: assert property (
        !$past(sys_rst) && $past(dog_period) == 3'h5 |-> dog_period_ms == 16'h01F4)
        else $error("period value wrong");
    chk_stop_suspend: assert property (
        !$past(sys_rst) && $past(chip_mode) == 2'h2 && $past(dog_stop_disable) |-> !dog_active)
        else $error("watchdog running in stop");
    chk_lowpower_can: assert property (
        !$past(sys_rst) && $past(chip_mode) != 2'h0 |-> can_mode != 2'h3)
        else $error("transceiver normal in low power");
endmodule // wdbus_chk
bind watchdog_and_bus_mode_control_regs wdbus_chk i_chk (.clk(clk), .sys_rst(sys_rst),
    .chip_mode(chip_mode), .bus_wake(bus_wake), .dog_fail(dog_fail), .spi_fail(spi_fail),
    .dog_active(dog_active), .dog_stop_disable(dog_stop_disable),
    .dog_start_on_bus_wake(dog_start_on_bus_wake), .dog_max_three(dog_max_three),
    .dog_period(dog_period), .dog_period_ms(dog_period_ms),
    .dog_long_window_start(dog_long_window_start), .dog_reset_req(dog_reset_req),
    .can_mode(can_mode));

// ==== wdbus_defines.vh ====
// constants for the watchdog and bus mode control register slice
`ifndef WDBUS_DEFINES_VH
`define WDBUS_DEFINES_VH
`define FRAME_BITS 16
`define WR_BIT 7
`define ADDR_DOG_CTRL 7'h03
`define ADDR_BUS_ONE 7'h04
`define ADDR_BUS_TWO 7'h05
`define DOG_POR 8'h14
`define BUS_ONE_POR 8'h20
`define BUS_TWO_POR 8'h00
`define DOG_RD_MASK 8'h7F
`define DOG_RESTART_KEEP 8'h18
`define DOG_RESTART_SET 8'h04
`define BUS_ONE_WMASK 8'hFB
`define BUS_TWO_WMASK 8'h1B
`define DOG_CHK_BIT 7
`define DOG_STOP_DIS_BIT 6
`define DOG_WIN_BIT 5
`define DOG_BUS_WAKE_BIT 4
`define DOG_MAX3_BIT 3
`define LIN_FLASH_BIT 7
`define LIN_LOW_SLOPE_BIT 6
`define LIN_TX_TO_BIT 5
`define MODE_NORMAL 2'h0
`define MODE_SLEEP 2'h1
`define MODE_STOP 2'h2
`define TRX_OFF 2'h0
`define TRX_WAKE 2'h1
`define TRX_RX_ONLY 2'h2
`define TRX_NORMAL 2'h3
`define DOG_MS_0 16'h000A
`define DOG_MS_1 16'h0014
`define DOG_MS_2 16'h0032
`define DOG_MS_3 16'h0064
`define DOG_MS_4 16'h00C8
`define DOG_MS_5 16'h01F4
`define DOG_MAX_RESETS 2'h3
`endif
